// [design/tths_pkg.sv]
// Purpose: constants shared by the trigger handshake sequencer
// Assumes: 100 MHz pclk, 32-bit apb data, six trigger bus lines
// Notes:   offsets, fields, reset values, timing and states below
package tths_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] LINE_OFS = 8'h04;
   localparam logic [7:0] MCNT_OFS = 8'h08;
   localparam logic [7:0] DLY_OFS  = 8'h0c;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] DONE_OFS = 8'h14;
   // control fields
   localparam int CTRL_SEMI_BIT  = 0;
   localparam int CTRL_SRC_BIT   = 1;
   localparam int CTRL_ARMIM_BIT = 2;
   localparam int CTRL_SCNIM_BIT = 3;
   localparam int CTRL_REARM_BIT = 4;
   // line select fields, three bits each, line #1 is index 0
   localparam int LINE_IN_POS   = 0;
   localparam int LINE_OUT_POS  = 4;
   localparam int LINE_SEMI_POS = 8;
   // reset values
   localparam logic [4:0]  CTRL_RST = 5'h0c;
   localparam logic [10:0] LINE_RST = 11'h010;
   localparam logic [15:0] MCNT_RST = 16'h0000;
   localparam logic [31:0] DLY_RST  = 32'h00000000;
   // timing
   localparam int CLK_NS     = 10;
   localparam int PULSE_NS   = 10000;
   localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_NS  = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int NLINES     = 6;
   // sequencer states
   typedef enum logic [2:0] {
      TTHS_ARM    = 3'b000,
      TTHS_SCAN   = 3'b001,
      TTHS_WAIT   = 3'b010,
      TTHS_MEAS   = 3'b011,
      TTHS_DELAY  = 3'b100,
      TTHS_SIGNAL = 3'b101,
      TTHS_DONE   = 3'b110
   } tths_state_t;
endpackage

// [design/tths_sync_edge.sv]
// Purpose: two-flop synchroniser with edge pulses per line
// Assumes: inputs asynchronous to pclk
// Notes:   edges come from flops two and three only
`timescale 1ns/100ps
module tths_sync_edge #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // lines
   input  wire logic [W-1:0] line_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] fall,
   output logic      [W-1:0] rise
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   initial begin
      if (W < 1) $error("width must be positive");
   end

   // idle bus rests high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '1;
         sync_reg <= '1;
         prev_reg <= '1;
      end else begin
         meta_reg <= line_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edge pulses
   assign level = sync_reg;
   assign fall  = prev_reg & ~sync_reg;
   assign rise  = ~prev_reg & sync_reg;
endmodule

// [design/tths_timer.sv]
// Purpose: loadable down counter with one-cycle expiry pulse
// Assumes: load wins over a running count
// Notes:   a value of 0 or 1 expires one cycle after load
`timescale 1ns/100ps
module tths_timer #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              expired
);
   logic [W-1:0] cnt_reg;
   logic         run_reg;

   initial begin
      if (W < 2) $error("timer too narrow");
   end

   // count down while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else if (load) begin
         cnt_reg <= value;
         run_reg <= 1'b1;
         expired <= 1'b0;
      end else begin
         expired <= run_reg && (cnt_reg <= W'(1));
         if (run_reg && cnt_reg <= W'(1)) run_reg <= 1'b0;
         if (cnt_reg != '0) cnt_reg <= cnt_reg - W'(1);
      end
   end
endmodule

// [design/tths_sequencer.sv]
// Purpose: trigger handshake sequencer on a shared trigger bus
// Assumes: measurement engine on pclk, apb slave for setup
// Notes:   bus lines are open drain, driven low or released
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
module tths_sequencer
   import tths_pkg::*;
#(
   parameter int NL = tths_pkg::NLINES
) (
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // shared trigger bus
   input  wire logic [NL-1:0] shared_trigger_bus_source_in,
   output logic      [NL-1:0] shared_trigger_bus_source_out,
   output logic      [NL-1:0] shared_trigger_bus_source_oe,
   // measurement engine
   output logic               meas_start,
   input  wire logic          meas_done,
   // status
   output logic               armed
);
   import tths_pkg::*;

   initial begin
      if (NL < 1 || NL > 8) $error("line count must be 1 to 8");
   end

   tths_state_t  state_reg;
   logic [4:0]   ctrl_reg;
   logic [10:0]  line_reg;
   logic [15:0]  mcnt_reg;
   logic [31:0]  dly_reg;
   logic [15:0]  done_cnt_reg;
   logic         first_pass_reg;
   logic         rearm_reg;
   logic         tmr_load_reg;
   logic [31:0]  tmr_val_reg;
   logic         tmr_exp;
   logic [NL-1:0] lvl;
   logic [NL-1:0] fall;
   logic [NL-1:0] rise;
   logic         semi;
   logic         src;
   logic         in_ev;
   logic         rise_ev;
   logic         line_low;
   logic         count_hit;
   logic         count_met;
   logic [31:0]  rd_data;
   logic         rd_ok;
   logic         apb_done;

   // one-hot mask of a line index, none if out of range
   function automatic logic [NL-1:0] line_mask(input logic [2:0] idx);
      logic [NL-1:0] m;
      m = '0;
      for (int i = 0; i < NL; i++) begin
         if (idx == 3'(i)) m[i] = 1'b1;
      end
      return m;
   endfunction

   // bus lines sampled through two flops before edge sensing
   tths_sync_edge #(.W(NL)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .line_in (shared_trigger_bus_source_in),
      .level   (lvl),
      .fall    (fall),
      .rise    (rise)
   );

   // delay, settling and pulse width timer
   tths_timer #(.W(32)) u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (tmr_load_reg),
      .value   (tmr_val_reg),
      .expired (tmr_exp)
   );

   // mode decode and trigger selection
   assign semi = ctrl_reg[CTRL_SEMI_BIT];
   assign src  = ctrl_reg[CTRL_SRC_BIT];
   assign in_ev = semi
      ? |(fall & line_mask(line_reg[LINE_SEMI_POS +: 3]))
      : |(fall & line_mask(line_reg[LINE_IN_POS +: 3]));
   // rise only seen once every party has let go
   assign rise_ev = |(rise & line_mask(line_reg[LINE_SEMI_POS +: 3]));
   assign line_low = ~|(lvl & line_mask(line_reg[LINE_SEMI_POS +: 3]));
   assign count_hit = (mcnt_reg != '0) &&
                      (done_cnt_reg + 16'h0001 == mcnt_reg);
   // done count already holds the reading that just ended
   assign count_met = (mcnt_reg != '0) &&
                      (done_cnt_reg == mcnt_reg);

   // apb read mux
   always_comb begin
      rd_data = '0;
      rd_ok   = 1'b1;
      unique case (paddr)
         CTRL_OFS: rd_data = {27'h0, 1'b0, ctrl_reg[3:0]};
         LINE_OFS: rd_data = {21'h0, line_reg};
         MCNT_OFS: rd_data = {16'h0, mcnt_reg};
         DLY_OFS:  rd_data = dly_reg;
         STAT_OFS: rd_data = {16'h0, 8'(lvl), 3'h0,
                              first_pass_reg, armed, state_reg};
         DONE_OFS: rd_data = {16'h0, done_cnt_reg};
         default:  rd_ok   = 1'b0;
      endcase
   end

   // apb handshake, one wait state per access
   assign apb_done = psel && penable && pready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_ok;
         if (psel && penable && !pready && !pwrite && rd_ok)
            prdata <= rd_data;
         else if (apb_done || !psel)
            prdata <= '0;
      end
   end

   // register writes; rearm bit is a self-clearing strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= CTRL_RST;
         line_reg  <= LINE_RST;
         mcnt_reg  <= MCNT_RST;
         dly_reg   <= DLY_RST;
         rearm_reg <= 1'b0;
      end else begin
         rearm_reg <= 1'b0;
         if (apb_done && pwrite) begin
            unique case (paddr)
               CTRL_OFS: begin
                  ctrl_reg  <= {1'b0, pwdata[3:0]};
                  rearm_reg <= pwdata[CTRL_REARM_BIT];
               end
               LINE_OFS: line_reg <= pwdata[10:0];
               MCNT_OFS: mcnt_reg <= pwdata[15:0];
               DLY_OFS:  dly_reg  <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // open-drain drive: output value is always low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) shared_trigger_bus_source_out <= '0;
      else          shared_trigger_bus_source_out <= '0;
   end

   // trigger model sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg      <= TTHS_ARM;
         first_pass_reg <= 1'b1;
         done_cnt_reg   <= '0;
         meas_start     <= 1'b0;
         tmr_load_reg   <= 1'b0;
         tmr_val_reg    <= '0;
         armed          <= 1'b0;
         shared_trigger_bus_source_oe <= '0;
      end else begin
         meas_start   <= 1'b0;
         tmr_load_reg <= 1'b0;
         armed        <= (state_reg != TTHS_DONE);
         if (rearm_reg) begin
            state_reg      <= TTHS_ARM;
            first_pass_reg <= 1'b1;
            done_cnt_reg   <= '0;
            shared_trigger_bus_source_oe <= '0;
         end else begin
            unique case (state_reg)
               // arm layer: immediate passes straight down
               TTHS_ARM: begin
                  if (ctrl_reg[CTRL_ARMIM_BIT] || in_ev)
                     state_reg <= TTHS_SCAN;
               end
               // scan layer: immediate passes straight down
               TTHS_SCAN: begin
                  if (ctrl_reg[CTRL_SCNIM_BIT] || in_ev)
                     state_reg <= TTHS_WAIT;
               end
               // measure layer wait for trigger
               TTHS_WAIT: begin
                  if (src && first_pass_reg) begin
                     first_pass_reg <= 1'b0;
                     meas_start     <= 1'b1;
                     state_reg      <= TTHS_MEAS;
                  end else if (semi && src) begin
                     if (rise_ev) begin
                        meas_start <= 1'b1;
                        state_reg  <= TTHS_MEAS;
                     end
                  end else if (in_ev) begin
                     meas_start <= 1'b1;
                     state_reg  <= TTHS_MEAS;
                     if (semi)
                        shared_trigger_bus_source_oe <=
                           line_mask(line_reg[LINE_SEMI_POS +: 3]);
                  end
               end
               // measurement running
               TTHS_MEAS: begin
                  if (meas_done) begin
                     tmr_load_reg <= 1'b1;
                     tmr_val_reg  <= dly_reg + 32'(SETTLE_CYC);
                     state_reg    <= TTHS_DELAY;
                  end
               end
               // user delay plus settling elapsed
               TTHS_DELAY: begin
                  if (tmr_exp) begin
                     done_cnt_reg <= done_cnt_reg + 16'h0001;
                     if (!semi) begin
                        shared_trigger_bus_source_oe <=
                           line_mask(line_reg[LINE_OUT_POS +: 3]);
                        tmr_load_reg <= 1'b1;
                        tmr_val_reg  <= 32'(PULSE_CYC);
                        state_reg    <= TTHS_SIGNAL;
                     end else if (src) begin
                        shared_trigger_bus_source_oe <=
                           line_mask(line_reg[LINE_SEMI_POS +: 3]);
                        state_reg <= TTHS_SIGNAL;
                     end else begin
                        shared_trigger_bus_source_oe <= '0;
                        state_reg <= count_hit ? TTHS_DONE : TTHS_WAIT;
                     end
                  end
               end
               // output pulse or source pull-down in progress
               TTHS_SIGNAL: begin
                  if (semi ? line_low : tmr_exp) begin
                     shared_trigger_bus_source_oe <= '0;
                     state_reg <= count_met ? TTHS_DONE : TTHS_WAIT;
                  end
               end
               // count reached: triggers ignored until rearm
               TTHS_DONE: state_reg <= TTHS_DONE;
               default: state_reg <= TTHS_ARM;
            endcase
         end
      end
   end
endmodule

// [dv/tths_chk_props.sv]
// Purpose: port-level checks on the trigger sequencer
// Assumes: single pclk domain, asynchronous active-low reset
// Notes:   bound to every sequencer instance below
`timescale 1ns/100ps
module tths_chk #(
   parameter int NL = 6
) (
   // clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // apb
   input wire logic          psel,
   input wire logic          penable,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   // trigger lines and engine
   input wire logic [NL-1:0] shared_trigger_bus_source_out,
   input wire logic [NL-1:0] shared_trigger_bus_source_oe,
   input wire logic          meas_start,
   input wire logic          meas_done,
   input wire logic          armed
);
   logic [11:0] since_done;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles since the last measurement finished, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_done <= 12'hfff;
      else if (meas_done) since_done <= 12'h000;
      else if (since_done != 12'hfff) since_done <= since_done + 12'h001;
   end
   a_out_never_high: assert property (
      shared_trigger_bus_source_out == '0) else $error("line driven high");
   a_armed_after_reset: assert property (
      $rose(presetn) |=> armed) else $error("not armed after reset");
   a_ready_one_wait: assert property (
      $rose(psel && penable) |=> pready) else $error("pready late");
   a_ready_in_access: assert property (
      pready |-> psel && penable && $past(penable))
      else $error("pready outside access");
   a_err_with_ready: assert property (
      pslverr |-> pready) else $error("pslverr without pready");
   a_data_idle_zero: assert property (
      !psel |-> prdata == 32'h0) else $error("prdata not zero");
   a_start_one_cycle: assert property (
      meas_start |=> !meas_start) else $error("start too long");
   a_start_when_armed: assert property (
      meas_start |-> armed) else $error("start while disarmed");
   a_delay_before_oe: assert property (
      $rose(|shared_trigger_bus_source_oe) |-> since_done >= 12'h064)
      else $error("line pulled before delay");
   // main scenarios
   c_start: cover property (meas_start);
   c_refused: cover property (pslverr);
   c_count_done: cover property ($fell(armed));
endmodule
bind tths_sequencer tths_chk #(.NL(NL)) tths_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .shared_trigger_bus_source_out(shared_trigger_bus_source_out),
   .shared_trigger_bus_source_oe(shared_trigger_bus_source_oe),
   .meas_start(meas_start), .meas_done(meas_done), .armed(armed)
);

// [dv/tths_scanner_model.sv]
// Purpose: scanner stand-in on the shared trigger lines
// Assumes: open-drain lines with pull-ups, levels seen directly
// Notes:   settle and strobe lengths are arbitrary choices
`timescale 1ns/100ps
module tths_scanner_model (
   // clock
   input  wire logic       pclk,
   // scan setup
   input  wire logic       start,
   input  wire logic       semi,
   input  wire logic       acc,
   input  wire logic [2:0] in_l,
   input  wire logic [2:0] out_l,
   input  wire logic [4:0] nch,
   // trigger lines
   input  wire logic [5:0] lvl,
   output logic      [5:0] oe,
   output logic            done
);
   // settling outlasts the meter's completion pulse
   localparam int SETTLE = tths_pkg::PULSE_CYC + 100;
   localparam int HOLD   = 20;
   // one scan per start, channels paced by the meter
   initial begin
      oe = 6'h00;
      done = 1'b0;
      forever begin
         @(posedge pclk);
         if (start) begin
            done <= 1'b0;
            for (int ch = 0; ch < nch; ch++) begin
               if (acc) begin
                  // acceptor: a falling edge closes the next channel
                  while (lvl[in_l] !== 1'b1) @(posedge pclk);
                  while (lvl[in_l] !== 1'b0) @(posedge pclk);
                  oe[out_l] <= 1'b1;
                  repeat (SETTLE) @(posedge pclk);
                  oe[out_l] <= 1'b0;
               end else begin
                  // only the first channel of a scan skips the wait
                  if (ch > 0) begin
                     while (lvl[in_l] === semi) @(posedge pclk);
                     while (lvl[in_l] !== semi) @(posedge pclk);
                  end
                  // relay settling, then the channel-ready strobe
                  repeat (SETTLE) @(posedge pclk);
                  oe[out_l] <= 1'b1;
                  repeat (HOLD) @(posedge pclk);
                  oe[out_l] <= 1'b0;
               end
            end
            // scan-layer strobe on the spare line #6
            @(posedge pclk);
            oe[5] <= 1'b1;
            repeat (HOLD) @(posedge pclk);
            oe[5] <= 1'b0;
            done <= 1'b1;
         end
      end
   end
endmodule

// [dv/tths_sequencer_tb_top.sv]
// Purpose: bench for the trigger handshake sequencer
// Assumes: scanner model on the lines, pull-up on every line
// Notes:   measurement engine is a fixed-latency stand-in
`timescale 1ns/100ps
module tths_sequencer_tb_top;
   import tths_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, meas_done = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, meas_start, armed, semi_chk = 1'b0;
   logic [5:0]  bus_in, bus_out, dev_oe, scn_oe, mcnt = 6'h00;
   logic        scn_start = 1'b0, scn_semi = 1'b0, scn_done;
   logic        src_chk = 1'b0, scn_acc = 1'b0;
   logic [2:0]  scn_in = 3'h0, scn_out = 3'h0;
   logic [4:0]  scn_nch = 5'h00;
   int          bad_count = 0, n_tests = 0, n_meas = 0, base;
   tths_sequencer tths_sequencer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .shared_trigger_bus_source_in(bus_in),
      .shared_trigger_bus_source_out(bus_out),
      .shared_trigger_bus_source_oe(dev_oe),
      .meas_start(meas_start), .meas_done(meas_done), .armed(armed)
   );
   tths_scanner_model tths_scanner_model_inst (
      .pclk(pclk), .start(scn_start), .semi(scn_semi), .acc(scn_acc),
      .in_l(scn_in), .out_l(scn_out), .nch(scn_nch), .lvl(bus_in),
      .oe(scn_oe),
      .done(scn_done)
   );
   // wired-and lines with pull-ups
   assign bus_in = ~(dev_oe | scn_oe);
   always #5 pclk = ~pclk;
   // measurement stand-in, done follows start after 40 cycles
   always @(posedge pclk) begin
      meas_done <= (mcnt == 6'h01);
      if (meas_start) begin
         mcnt <= 6'h28;
         n_meas <= n_meas + 1;
      end else if (mcnt != 6'h00) mcnt <= mcnt - 6'h01;
   end
   // at completion the device still holds the released line low
   always @(negedge pclk) if (semi_chk && meas_done) begin
      cmp_bit(dev_oe[0], 1'b1);
      cmp_bit(bus_in[0], 1'b0);
   end
   // a source reading starts only once every party has let go
   always @(negedge pclk) if (src_chk && meas_start)
      cmp_bit(bus_in[0], 1'b1);
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // access phase lasts until pready is seen at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp_word(rd, exp);
   endtask
   // 0: scanner done, 1: disarmed, 2: device pulls line #1
   task automatic wait_for(input int which, input int lim);
      int n;
      n = 0;
      while (n < lim && (which == 0 ? scn_done : which == 1 ? !armed
             : dev_oe[0]) !== 1'b1) begin
         @(negedge pclk);
         n++;
      end
      if (n >= lim) begin
         bad_count++;
         tally_and_finish;
      end
   endtask
   task automatic scan(input logic s, input logic [2:0] i, input logic [2:0] o,
                       input logic [4:0] c);
      @(posedge pclk);
      scn_semi <= s;
      scn_in <= i;
      scn_out <= o;
      scn_nch <= c;
      scn_start <= 1'b1;
      @(posedge pclk);
      scn_start <= 1'b0;
      @(posedge pclk);
      wait_for(0, 30000);
   endtask
   // main sequence
   initial begin
      do_reset;
      rchk(CTRL_OFS, 32'h0000000c);
      rchk(LINE_OFS, 32'h00000010);
      rchk(MCNT_OFS, 32'h0);
      apb(1'b0, STAT_OFS, 32'h0);
      cmp_word({29'h0, rd[2:0]}, {29'h0, TTHS_WAIT});
      cmp_bit(armed, 1'b1);
      apb(1'b1, 8'h18, 32'hffffffff);
      cmp_bit(err, 1'b1);
      rchk(8'h18, 32'h0);
      // asynchronous acceptor: input line #3, output line #4
      apb(1'b1, MCNT_OFS, 32'h3);
      apb(1'b1, DLY_OFS, 32'h5);
      apb(1'b1, LINE_OFS, 32'h32);
      rchk(LINE_OFS, 32'h32);
      scan(1'b0, 3'h3, 3'h2, 5'h03);
      wait_for(1, 3000);
      cmp_word(n_meas, 32'h3);
      rchk(DONE_OFS, 32'h3);
      scan(1'b0, 3'h3, 3'h2, 5'h01);
      cmp_word(n_meas, 32'h3);
      // semi-synchronous acceptor on line #1
      do_reset;
      apb(1'b1, MCNT_OFS, 32'h2);
      apb(1'b1, CTRL_OFS, 32'h0000000d);
      semi_chk = 1'b1;
      base = n_meas;
      scan(1'b1, 3'h0, 3'h0, 5'h02);
      wait_for(1, 3000);
      cmp_word(n_meas - base, 32'h2);
      cmp_word({26'h0, dev_oe}, 32'h0);
      // semi-synchronous source, first reading needs no trigger
      semi_chk = 1'b0;
      do_reset;
      base = n_meas;
      src_chk = 1'b1;
      scn_acc <= 1'b1;
      // scanner as acceptor holds the line while its relay settles
      fork
         scan(1'b1, 3'h0, 3'h0, 5'h02);
      join_none
      apb(1'b1, MCNT_OFS, 32'h2);
      apb(1'b1, CTRL_OFS, 32'h0000000f);
      wait_for(2, 2000);
      wait_for(1, 3000);
      cmp_word(n_meas - base, 32'h2);
      wait_for(0, 3000);
      cmp_word({26'h0, dev_oe}, 32'h0);
      tally_and_finish;
   end
endmodule
